// File: shared/isi_pkg.sv
`default_nettype none
package isi_pkg;
    // Register byte addresses
    localparam logic [7:0] ISI_ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ISI_ADDR_MODE    = 8'h04;
    localparam logic [7:0] ISI_ADDR_BAUD    = 8'h08;
    localparam logic [7:0] ISI_ADDR_TIMEOUT = 8'h0C;
    localparam logic [7:0] ISI_ADDR_ALARM   = 8'h10;
    localparam logic [7:0] ISI_ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ISI_ADDR_LINK    = 8'h18;
    // CTRL fields
    localparam int ISI_CTRL_FIL0  = 0;
    localparam int ISI_CTRL_FIL1  = 1;
    localparam int ISI_CTRL_MULT  = 2;
    localparam int ISI_CTRL_TPM   = 3;
    localparam int ISI_CTRL_SRST  = 4;
    // MODE fields
    localparam int ISI_MODE_ALARM = 0;
    localparam int ISI_MODE_LEAK  = 1;
    localparam int ISI_MODE_POLL  = 2;
    localparam int ISI_MODE_HOST  = 3;
    // LINK fields
    localparam int ISI_LINK_CHAR  = 0;
    localparam int ISI_LINK_POLL  = 1;
    // Timing and reset values
    localparam int          ISI_CLK_HZ      = 10_000_000;
    localparam int          ISI_BAUD_RATE   = 9600;
    localparam logic [15:0] ISI_BAUD_DIV    = 16'(ISI_CLK_HZ / ISI_BAUD_RATE);
    localparam int          ISI_TIMEOUT_MS  = 1000;
    localparam int          ISI_TIMEOUT_CYC = ISI_CLK_HZ / 1000 * ISI_TIMEOUT_MS;
    localparam int          ISI_NCHAN       = 12;
endpackage
`default_nettype wire

// File: hw/isi_alarm_chan.sv
`timescale 1ns/1ps
`default_nettype none
module isi_alarm_chan
    import isi_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         enable,
    input  wire logic [W-1:0] peak,
    input  wire logic [W-1:0] highLimit,
    input  wire logic [W-1:0] lowLimit,
    output logic              alarm
);
    logic next_alarm;

    always_comb begin
        next_alarm = enable && ((peak > highLimit) || (peak < lowLimit));
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm <= 1'b0;
        end else begin
            alarm <= next_alarm;
        end
    end
endmodule
`default_nettype wire

// File: hw/isi_link_timer.sv
`timescale 1ns/1ps
`default_nettype none
module isi_link_timer
    import isi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clear,
    input  wire logic        kick,
    input  wire logic [31:0] limit,
    output logic             expired
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_expired;

    always_comb begin
        next_count   = count;
        next_expired = expired;
        if (clear || kick) begin
            next_count   = 32'h0;
            next_expired = 1'b0;
        end else if (count >= limit) begin
            next_expired = 1'b1;
        end else begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            count   <= 32'h0;
            expired <= 1'b0;
        end else begin
            count   <= next_count;
            expired <= next_expired;
        end
    end
endmodule
`default_nettype wire

// File: hw/isi_interlock.sv
// Behaviour
// - Handshake inputs ignored, treated as asserted
// - Link rate defaults to 9600 baud
// - Alarm high when peak outside limits
// - Selected-mass mode gives twelve channel alarms
// - Leak-check mode alarms on channel one only
// - Analog module blocked by alarm/host; port dedicated
// - External trip protects filaments and multiplier
// - External reset equals power-up reset
// - Link-ok off until first character or poll
// - Polling mode: link-ok off when link lost
// - Text mode: link-ok held until reset
// - Never two filaments energised at once
// - Filament LED needs supply on, current good
// - Detector LEDs are exact complements
// - Detector LEDs show hardware-selected detector
// - Multiplier refused while filaments off
// - Multiplier request replaced by every CTRL write
// - Collector used during total-pressure measurement
`timescale 1ns/1ps
`default_nettype none
module isi_interlock
    import isi_pkg::*;
#(
    parameter int PEAK_W      = 16,
    parameter int TIMEOUT_CYC = ISI_TIMEOUT_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        extReset,
    input  wire logic                        extTrip,
    input  wire logic                        dsrIn,
    input  wire logic                        ctsIn,
    input  wire logic                        charRx,
    input  wire logic                        pollRx,
    input  wire logic [1:0]                  filCurrentOk,
    input  wire logic                        analogModFitted,
    input  wire logic                        tpmActive,
    input  wire logic [ISI_NCHAN-1:0]        peakValid,
    input  wire logic [ISI_NCHAN*PEAK_W-1:0] peakValue,
    input  wire logic [7:0]                  regAddr,
    input  wire logic [31:0]                 regWdata,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic [31:0]                      regRdata,
    output logic [15:0]                      baudDiv,
    output logic                             txEnable,
    output logic [1:0]                       filSupplyOn,
    output logic                             multOn,
    output logic [1:0]                       filLed,
    output logic                             collectorLed,
    output logic                             multLed,
    output logic                             linkOkLed,
    output logic [ISI_NCHAN-1:0]             alarmOut,
    output logic                             analogOutEn
);
    // Power-up and external reset act alike
    logic rst;
    assign rst = sys_rst | extReset;

    logic [4:0]             ctrl;
    logic [3:0]             mode;
    logic [15:0]            baudReg;
    logic [31:0]            timeoutReg;
    logic [PEAK_W-1:0]      highLim;
    logic [PEAK_W-1:0]      lowLim;
    logic [1:0]             filOn;
    logic                   multReq;
    logic                   linkUp;
    logic                   everPolled;
    logic [4:0]             next_ctrl;
    logic [3:0]             next_mode;
    logic [15:0]            next_baudReg;
    logic [31:0]            next_timeoutReg;
    logic [PEAK_W-1:0]      next_highLim;
    logic [PEAK_W-1:0]      next_lowLim;
    logic [1:0]             next_filOn;
    logic                   next_multReq;
    logic                   next_linkUp;
    logic                   next_everPolled;
    logic [31:0]            next_rdata;
    logic [1:0]             next_filLed;
    logic                   next_multOn;
    logic [ISI_NCHAN-1:0]   chanAlarm;
    logic [ISI_NCHAN-1:0]   next_alarmOut;
    logic                   linkLost;
    logic                   softReset;
    logic                   wrCtrl;

    assign wrCtrl    = regWr && (regAddr == ISI_ADDR_CTRL);
    assign softReset = wrCtrl && regWdata[ISI_CTRL_SRST];

    // Configuration registers
    always_comb begin
        next_ctrl       = ctrl;
        next_mode       = mode;
        next_baudReg    = baudReg;
        next_timeoutReg = timeoutReg;
        next_highLim    = highLim;
        next_lowLim     = lowLim;
        if (regWr) begin
            unique case (regAddr)
                ISI_ADDR_CTRL:    next_ctrl = {1'b0, regWdata[3:0]};
                ISI_ADDR_MODE:    next_mode = regWdata[3:0];
                ISI_ADDR_BAUD:    next_baudReg = regWdata[15:0];
                ISI_ADDR_TIMEOUT: next_timeoutReg = regWdata;
                ISI_ADDR_ALARM: begin
                    next_highLim = regWdata[31:16];
                    next_lowLim  = regWdata[PEAK_W-1:0];
                end
                default: ;
            endcase
        end
        if (extTrip) begin
            next_ctrl[ISI_CTRL_FIL0] = 1'b0;
            next_ctrl[ISI_CTRL_FIL1] = 1'b0;
            next_ctrl[ISI_CTRL_MULT] = 1'b0;
        end
    end

    // Filament and multiplier interlock
    always_comb begin
        next_filOn   = 2'b00;
        next_multReq = multReq;
        if (wrCtrl) begin
            next_multReq = regWdata[ISI_CTRL_MULT];
        end
        if (next_ctrl[ISI_CTRL_FIL0]) begin
            next_filOn = 2'b01;
        end else if (next_ctrl[ISI_CTRL_FIL1]) begin
            next_filOn = 2'b10;
        end
        if (extTrip) begin
            next_filOn   = 2'b00;
            next_multReq = 1'b0;
        end
        next_multOn = next_multReq && (next_filOn != 2'b00)
                      && !(ctrl[ISI_CTRL_TPM] && tpmActive);
        next_filLed = next_filOn & filCurrentOk;
    end

    // Interlock checks
    chk_mult_stored: assert property (@(posedge clk) disable iff (rst)
        (multReq && !wrCtrl && !extTrip && (next_filOn != 2'h0) && !ctrl[ISI_CTRL_TPM]) |=> multOn)
        else $error("stored multiplier request not applied");
    chk_tpm_collector: assert property (@(posedge clk) disable iff (rst)
        (ctrl[ISI_CTRL_TPM] && tpmActive) |=> (collectorLed && !multOn))
        else $error("multiplier kept during total pressure");
    chk_mult_refused: assert property (@(posedge clk) disable iff (rst)
        (filSupplyOn == 2'h0) |-> !multLed)
        else $error("multiplier led lit with filaments off");
    chk_trip_clears: assert property (@(posedge clk) disable iff (rst)
        extTrip |=> (!multReq && !ctrl[ISI_CTRL_MULT] && !ctrl[ISI_CTRL_FIL0] && !ctrl[ISI_CTRL_FIL1]))
        else $error("trip left a request standing");
    chk_fil_led_ok: assert property (@(posedge clk) disable iff (rst)
        (filLed & ~$past(filCurrentOk)) == 2'h0)
        else $error("filament led with current out of limits");

    // Link-ok state
    always_comb begin
        next_linkUp     = linkUp;
        next_everPolled = everPolled;
        if (softReset) begin
            next_linkUp     = 1'b0;
            next_everPolled = 1'b0;
        end
        if (mode[ISI_MODE_POLL] && everPolled && linkLost && !pollRx) begin
            next_linkUp = 1'b0;
        end
        // Arriving traffic wins over a clear in the same cycle
        if (charRx || pollRx) begin
            next_linkUp = 1'b1;
        end
        if (pollRx) begin
            next_everPolled = 1'b1;
        end
    end

    // Link checks
    chk_link_start: assert property (@(posedge clk) disable iff (rst)
        (!linkOkLed && !charRx && !pollRx) |=> !linkOkLed)
        else $error("link-ok lit without traffic");
    chk_link_lost: assert property (@(posedge clk) disable iff (rst)
        (mode[ISI_MODE_POLL] && everPolled && linkLost && !pollRx && !charRx) |=> !linkOkLed)
        else $error("link-ok kept after link loss");
    chk_soft_reset: assert property (@(posedge clk) disable iff (rst)
        (softReset && !charRx && !pollRx) |=> !linkOkLed)
        else $error("link-ok kept after reset command");

    // Alarm routing
    always_comb begin
        next_alarmOut = '0;
        if (mode[ISI_MODE_ALARM] && !analogModFitted) begin
            if (mode[ISI_MODE_LEAK]) begin
                next_alarmOut[0] = chanAlarm[0];
            end else begin
                next_alarmOut = chanAlarm;
            end
        end
    end

    // Alarm checks
    chk_alarm_off: assert property (@(posedge clk) disable iff (rst)
        !$past(mode[ISI_MODE_ALARM]) |-> (alarmOut == '0))
        else $error("alarm output outside alarm mode");
    chk_alarm_all: assert property (@(posedge clk) disable iff (rst)
        ($past(mode[ISI_MODE_ALARM]) && !$past(mode[ISI_MODE_LEAK]) && !$past(analogModFitted))
        |-> (alarmOut == $past(chanAlarm)))
        else $error("channel alarm not routed");
    chk_analog_free: assert property (@(posedge clk) disable iff (rst)
        $past(analogModFitted) |-> (alarmOut == '0))
        else $error("alarm output with analog module fitted");

    // Read mux
    always_comb begin
        next_rdata = 32'h0;
        if (regRd) begin
            unique case (regAddr)
                ISI_ADDR_CTRL:    next_rdata = {28'h0, ctrl[3:0]};
                ISI_ADDR_MODE:    next_rdata = {28'h0, mode};
                ISI_ADDR_BAUD:    next_rdata = {16'h0, baudReg};
                ISI_ADDR_TIMEOUT: next_rdata = timeoutReg;
                ISI_ADDR_ALARM:   next_rdata = {highLim, lowLim};
                ISI_ADDR_STATUS:  next_rdata = {16'h0, alarmOut[11:0], multOn, filOn, linkUp};
                ISI_ADDR_LINK:    next_rdata = {30'h0, everPolled, linkUp};
                default:          next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl         <= 5'h00;
            mode         <= 4'h0;
            baudReg      <= ISI_BAUD_DIV;
            timeoutReg   <= 32'(TIMEOUT_CYC);
            highLim      <= '1;
            lowLim       <= '0;
            filOn        <= 2'b00;
            multReq      <= 1'b0;
            linkUp       <= 1'b0;
            everPolled   <= 1'b0;
            regRdata     <= 32'h0;
            baudDiv      <= ISI_BAUD_DIV;
            txEnable     <= 1'b1;
            filSupplyOn  <= 2'b00;
            multOn       <= 1'b0;
            filLed       <= 2'b00;
            collectorLed <= 1'b1;
            multLed      <= 1'b0;
            linkOkLed    <= 1'b0;
            alarmOut     <= '0;
            analogOutEn  <= 1'b0;
        end else begin
            ctrl         <= next_ctrl;
            mode         <= next_mode;
            baudReg      <= next_baudReg;
            timeoutReg   <= next_timeoutReg;
            highLim      <= next_highLim;
            lowLim       <= next_lowLim;
            filOn        <= next_filOn;
            multReq      <= next_multReq;
            linkUp       <= next_linkUp;
            everPolled   <= next_everPolled;
            regRdata     <= next_rdata;
            baudDiv      <= baudReg;
            txEnable     <= 1'b1;
            filSupplyOn  <= next_filOn;
            multOn       <= next_multOn;
            filLed       <= next_filLed;
            collectorLed <= !next_multOn;
            multLed      <= next_multOn;
            linkOkLed    <= next_linkUp;
            alarmOut     <= next_alarmOut;
            analogOutEn  <= analogModFitted && !mode[ISI_MODE_ALARM] && !mode[ISI_MODE_HOST];
        end
    end

    // Handshake levels are deliberately unused
    logic unusedHs;
    assign unusedHs = dsrIn ^ ctsIn;

    isi_link_timer u_timer (
        .clk     (clk),
        .sys_rst (rst),
        .clear   (softReset),
        .kick    (pollRx),
        .limit   (timeoutReg),
        .expired (linkLost)
    );

    genvar gi;
    generate
        for (gi = 0; gi < ISI_NCHAN; gi++) begin : g_chan
            isi_alarm_chan #(.W(PEAK_W)) u_chan (
                .clk       (clk),
                .sys_rst   (rst),
                .enable    (peakValid[gi]),
                .peak      (peakValue[gi*PEAK_W +: PEAK_W]),
                .highLimit (highLim),
                .lowLimit  (lowLim),
                .alarm     (chanAlarm[gi])
            );
        end
    endgenerate

    chk_one_filament: assert property (@(posedge clk) disable iff (rst) !(filSupplyOn == 2'b11))
        else $error("two filaments on");
    chk_mult_needs_fil: assert property (@(posedge clk) disable iff (rst) multOn |-> (filSupplyOn != 2'b00))
        else $error("multiplier on without filament");
    chk_led_complement: assert property (@(posedge clk) disable iff (rst) collectorLed != multLed)
        else $error("detector leds not complementary");
    chk_led_actual: assert property (@(posedge clk) disable iff (rst) multLed == multOn)
        else $error("detector led differs from hardware");
    chk_trip_kills: assert property (@(posedge clk) disable iff (rst) extTrip |=> (filSupplyOn == 2'b00 && !multOn))
        else $error("trip did not switch off");
    chk_fil_led: assert property (@(posedge clk) disable iff (rst) (filLed & ~filSupplyOn) == 2'b00)
        else $error("filament led without supply");
    chk_leak_ch1: assert property (@(posedge clk) disable iff (rst)
        $past(mode[ISI_MODE_LEAK]) |-> (alarmOut[ISI_NCHAN-1:1] == '0))
        else $error("leak alarm off channel one");
    chk_link_hold: assert property (@(posedge clk) disable iff (rst)
        (linkOkLed && !mode[ISI_MODE_POLL] && !softReset) |=> linkOkLed)
        else $error("link-ok dropped in text mode");
    chk_tx_free: assert property (@(posedge clk) disable iff (rst) txEnable)
        else $error("transmit blocked");
    chk_analog_block: assert property (@(posedge clk) disable iff (rst)
        (mode[ISI_MODE_ALARM] || mode[ISI_MODE_HOST]) |=> !analogOutEn)
        else $error("analog output usable in alarm or host mode");
    chk_analog_on: assert property (@(posedge clk) disable iff (rst)
        (analogModFitted && !mode[ISI_MODE_ALARM] && !mode[ISI_MODE_HOST]) |=> analogOutEn)
        else $error("analog output blocked without cause");
    chk_baud_follow: assert property (@(posedge clk) disable iff (rst)
        baudDiv == $past(baudReg))
        else $error("baud divider not applied");
    chk_fil_pick: assert property (@(posedge clk) disable iff (rst)
        (next_ctrl[ISI_CTRL_FIL0] && !extTrip) |=> (filSupplyOn == 2'h1))
        else $error("filament zero not preferred");
    chk_trip_leds: assert property (@(posedge clk) disable iff (rst)
        extTrip |=> ((filLed == 2'h0) && !multLed))
        else $error("indicators lit after trip");
endmodule
`default_nettype wire

// File: test/isi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module isi_host_model (
    input  wire logic clk,
    output logic      charRx,
    output logic      pollRx,
    output logic      dsrIn,
    output logic      ctsIn
);
    initial begin
        charRx = 1'h0;
        pollRx = 1'h0;
        dsrIn  = 1'h1;
        ctsIn  = 1'h1;
    end

    // Lets a scenario drop the handshake lines the unit should not care about
    task automatic set_handshake(input logic level);
        @(posedge clk);
        dsrIn <= level;
        ctsIn <= level;
    endtask

    // One received command character, one clock long
    task automatic send_char();
        @(posedge clk);
        charRx <= 1'h1;
        @(posedge clk);
        charRx <= 1'h0;
    endtask

    task automatic send_poll();
        @(posedge clk);
        pollRx <= 1'h1;
        @(posedge clk);
        pollRx <= 1'h0;
    endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import isi_pkg::*;
;
    logic                 clk, sysRst, extReset, extTrip, analogModFitted, tpmActive, regWr, regRd;
    logic [1:0]           filCurrentOk;
    logic [ISI_NCHAN-1:0] peakValid, expAlarm;
    logic [191:0]         peakValue;
    logic [7:0]           regAddr;
    logic [31:0]          regWdata, rdv;
    wire logic            charRx, pollRx, dsrIn, ctsIn, txEnable, multOn, collectorLed, multLed;
    wire logic            linkOkLed, analogOutEn;
    wire logic [31:0]     regRdata;
    wire logic [15:0]     baudDiv;
    wire logic [1:0]      filSupplyOn, filLed;
    wire logic [11:0]     alarmOut;
    int                   failures, nChecks;
    // Detector and filament state: mult, multLed, collectorLed, supply[1:0], led[1:0]
    wire logic [6:0]      det = {multOn, multLed, collectorLed, filSupplyOn, filLed};

    isi_interlock #(.PEAK_W(16), .TIMEOUT_CYC(50)) isi_interlock_inst (
        .clk(clk), .sys_rst(sysRst), .extReset(extReset), .extTrip(extTrip), .dsrIn(dsrIn),
        .ctsIn(ctsIn), .charRx(charRx), .pollRx(pollRx), .filCurrentOk(filCurrentOk),
        .analogModFitted(analogModFitted), .tpmActive(tpmActive), .peakValid(peakValid),
        .peakValue(peakValue), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .baudDiv(baudDiv), .txEnable(txEnable),
        .filSupplyOn(filSupplyOn), .multOn(multOn), .filLed(filLed), .collectorLed(collectorLed),
        .multLed(multLed), .linkOkLed(linkOkLed), .alarmOut(alarmOut), .analogOutEn(analogOutEn));
    isi_host_model isi_host_model_inst (
        .clk(clk), .charRx(charRx), .pollRx(pollRx), .dsrIn(dsrIn), .ctsIn(ctsIn));

    always #50 clk = ~clk;

    task automatic end_of_test();
        $display("Checks made: %0d, mismatches: %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'h1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'h0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd   <= 1'h1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'h0;
        #1;
        d = regRdata;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_of_test();
    end

    initial begin
        clk = 1'h0; sysRst = 1'h1; extReset = 1'h0; extTrip = 1'h0; analogModFitted = 1'h0;
        tpmActive = 1'h0; filCurrentOk = 2'h3; peakValid = 12'hFFF; peakValue = 192'h0;
        regAddr = 8'h00; regWdata = 32'h0; regWr = 1'h0; regRd = 1'h0;
        repeat (6) @(posedge clk);
        sysRst <= 1'h0;
        tick(2);
        check("baudDiv", 32'(baudDiv), 32'(ISI_BAUD_DIV));
        check("det", 32'(det), 32'h10);
        check("linkOkLed", 32'(linkOkLed), 32'h0);
        check("regRdata", regRdata, 32'h0);
        isi_host_model_inst.set_handshake(1'h0);
        tick(3);
        check("txEnable", 32'(txEnable), 32'h1);
        wr(ISI_ADDR_CTRL, 32'h4);
        tick(3);
        check("det", 32'(det), 32'h10);
        wr(ISI_ADDR_CTRL, 32'h5);
        tick(3);
        check("det", 32'(det), 32'h65);
        @(posedge clk) filCurrentOk <= 2'h2;
        tick(3);
        check("det", 32'(det), 32'h64);
        @(posedge clk) filCurrentOk <= 2'h3;
        wr(ISI_ADDR_CTRL, 32'h7);
        tick(3);
        check("det", 32'(det), 32'h65);
        wr(ISI_ADDR_CTRL, 32'hD);
        tpmActive <= 1'h1;
        tick(3);
        check("detLeds", 32'({collectorLed, multLed}), 32'h2);
        @(posedge clk) tpmActive <= 1'h0;
        tick(3);
        check("detLeds", 32'({collectorLed, multLed}), 32'h1);
        @(posedge clk) extTrip <= 1'h1;
        tick(3);
        check("det", 32'(det), 32'h10);
        @(posedge clk) extTrip <= 1'h0;
        rd(ISI_ADDR_CTRL, rdv);
        check("ctrlReq", rdv & 32'h7, 32'h0);
        wr(ISI_ADDR_CTRL, 32'h1);
        tick(3);
        check("det", 32'(det), 32'h15);
        wr(ISI_ADDR_BAUD, 32'h123);
        rd(ISI_ADDR_BAUD, rdv);
        check("baudReg", rdv, 32'h123);
        check("baudDiv", 32'(baudDiv), 32'h123);
        rd(8'h1C, rdv);
        check("unmapped", rdv, 32'h0);
        wr(ISI_ADDR_TIMEOUT, 32'h14);
        isi_host_model_inst.send_char();
        tick(3);
        check("linkOkLed", 32'(linkOkLed), 32'h1);
        tick(60);
        check("linkOkLed", 32'(linkOkLed), 32'h1);
        wr(ISI_ADDR_CTRL, 32'h10);
        tick(3);
        check("linkOkLed", 32'(linkOkLed), 32'h0);
        wr(ISI_ADDR_MODE, 32'h4);
        isi_host_model_inst.send_poll();
        tick(3);
        check("linkOkLed", 32'(linkOkLed), 32'h1);
        repeat (6) begin
            tick(10);
            isi_host_model_inst.send_poll();
        end
        tick(3);
        check("linkOkLed", 32'(linkOkLed), 32'h1);
        tick(40);
        check("linkOkLed", 32'(linkOkLed), 32'h0);
        @(posedge clk);
        for (int i = 0; i < ISI_NCHAN; i++) begin
            // Limits 50..100: 49 and 101 are out, 50 and 100 are in
            case (i % 4)
                0: peakValue[i*16 +: 16] <= 16'h0031;
                1: peakValue[i*16 +: 16] <= 16'h0032;
                2: peakValue[i*16 +: 16] <= 16'h0064;
                default: peakValue[i*16 +: 16] <= 16'h0065;
            endcase
            expAlarm[i] = (i % 4 == 0) || (i % 4 == 3);
        end
        wr(ISI_ADDR_ALARM, 32'h0064_0032);
        wr(ISI_ADDR_MODE, 32'h1);
        tick(4);
        check("alarmOut", 32'(alarmOut), 32'(expAlarm));
        wr(ISI_ADDR_MODE, 32'h3);
        tick(4);
        check("alarmOut", 32'(alarmOut), 32'h001);
        @(posedge clk) analogModFitted <= 1'h1;
        tick(4);
        check("alarmOut", 32'(alarmOut), 32'h0);
        check("analogOutEn", 32'(analogOutEn), 32'h0);
        wr(ISI_ADDR_MODE, 32'h0);
        tick(3);
        check("analogOutEn", 32'(analogOutEn), 32'h1);
        wr(ISI_ADDR_MODE, 32'h8);
        tick(3);
        check("analogOutEn", 32'(analogOutEn), 32'h0);
        wr(ISI_ADDR_CTRL, 32'h5);
        isi_host_model_inst.send_char();
        tick(3);
        @(posedge clk) extReset <= 1'h1;
        tick(2);
        @(posedge clk) extReset <= 1'h0;
        tick(2);
        check("det", 32'(det), 32'h10);
        check("baudDiv", 32'(baudDiv), 32'(ISI_BAUD_DIV));
        check("linkOkLed", 32'(linkOkLed), 32'h0);
        // Reset clears host mode, so the fitted analog module is usable again
        check("analogOutEn", 32'(analogOutEn), 32'h1);
        rd(ISI_ADDR_TIMEOUT, rdv);
        check("timeoutReg", rdv, 32'h32);
        end_of_test();
    end
endmodule
`default_nettype wire
